// *** vicc_core.sv ***
// video input colour converter: expansion, palette, colour key, byte select, tables
// assumes an apb master on the register port and synchronous image bus strobes
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - input strobe converts the image bus word and stores it in vbus
// - expansion format comes from control-one bits 31 to 29
// - added low bits copy each component's top bits
// - codes: pass, 1555, 565, 4444, 0555, 565 with red and blue swapped
// - palette flag selects 256-entry lookup of the low byte
// - key compares components to low/high limits, four enables
// - no key enable set passes alpha unchanged
// - any enable: alpha zero inside every enabled range, else ff
// - edge alpha replaces opaque neighbours of transparent pixels; ff disables
// - each vbus byte picks any input byte by a two-bit code
// - byte selection only when select-enable bit 9 is set
// - two-bit item width tag is attached to vbus data
// - feedback with no input strobe or flush in its cycle picks one of eight buses, byte-selects, result next cycle
// - table address bits 8 to 0, choice bit 9: palette or reverse
// - tables read only while read flag set; software clears it otherwise
// - table data writes, and reads while the read flag is set, pass the data register and auto-increment
// - a control-two write with the read flag set starts two-cycle pre-load if address, choice or flag changes
// - palette entry: alpha, red, green, blue from top byte down
// - reverse index is red plus eight green plus sixty-four blue
// - level counts per component limit the reverse indices
// - reverse entry: pseudo colour, three errors, three neighbour fields
// - neighbour bit 1 flags higher entry, bit 0 lower entry
module vicc_core (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [7:0]   paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic         in_go,
   input  wire logic [31:0]  in_data,
   input  wire logic         in_flush,
   input  wire logic         fb_go,
   input  wire logic [2:0]   fb_sel,
   input  wire logic [255:0] fb_buses,
   output logic      [31:0]  vbus_data_q,
   output logic      [1:0]   vbus_size_q,
   output logic              vbus_valid_q,
   input  wire logic [2:0]   rev_red,
   input  wire logic [2:0]   rev_green,
   input  wire logic [2:0]   rev_blue,
   output logic      [7:0]   rev_pseudo_q,
   output logic      [17:0]  rev_error_q,
   output logic      [5:0]   rev_next_q
);
   import vicc_pkg::*;

   logic [31:0] ctrl1_q;
   logic [31:0] ctrl2_q;
   logic [31:0] alpha_q;
   logic [31:0] keylo_q;
   logic [31:0] keyhi_q;
   logic [31:0] pal_mem [0:PAL_DEPTH-1];
   logic [31:0] rev_mem [0:REV_DEPTH-1];
   logic [31:0] buf0_q;
   logic [31:0] buf1_q;
   vicc_pl_type pl_q;
   vicc_pl_type pl_d;
   logic [31:0] hold_q;
   logic        hold_t_q;
   logic        hold_v_q;
   logic        prev_t_q;

   function automatic logic [7:0] x5(input logic [4:0] v);
      x5 = {v, v[4:2]};
   endfunction

   function automatic logic [7:0] x6(input logic [5:0] v);
      x6 = {v, v[5:4]};
   endfunction

   function automatic logic [31:0] expand(input logic [2:0] f, input logic [31:0] d);
      case (f)
         FMT_1555: expand = {{8{d[15]}}, x5(d[14:10]), x5(d[9:5]), x5(d[4:0])};
         FMT_565:  expand = {ALPHA_OPAQUE, x5(d[15:11]), x6(d[10:5]), x5(d[4:0])};
         FMT_4444: expand = {d[15:12], d[15:12], d[11:8], d[11:8],
                             d[7:4], d[7:4], d[3:0], d[3:0]};
         FMT_0555: expand = {ALPHA_OPAQUE, x5(d[14:10]), x5(d[9:5]), x5(d[4:0])};
         FMT_R565: expand = {ALPHA_OPAQUE, x5(d[4:0]), x6(d[10:5]), x5(d[15:11])};
         default:  expand = d;
      endcase
   endfunction

   function automatic logic [31:0] bsel(input logic [31:0] w, input logic [7:0] s,
                                         input logic en);
      logic [31:0] r;
      r = w;
      for (int i = 0; i < 4; i++) begin
         if (en) begin
            r[8*i +: 8] = w[8*s[2*i +: 2] +: 8];
         end
      end
      bsel = r;
   endfunction

   function automatic logic key_hit(input logic [31:0] c, input logic [31:0] lo,
                                    input logic [31:0] hi, input logic [3:0] en);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (en[i] && (c[8*i +: 8] < lo[8*i +: 8] || c[8*i +: 8] > hi[8*i +: 8])) begin
            ok = 1'b0;
         end
      end
      key_hit = ok;
   endfunction

   function automatic logic [2:0] lim(input logic [2:0] v, input logic [2:0] n);
      lim = (n == 3'h0 || v < n) ? v : n - 3'h1;
   endfunction

   function automatic logic [31:0] tab_rd(input logic ts, input logic [8:0] a);
      if (ts) begin
         tab_rd = (a < 9'(REV_DEPTH)) ? rev_mem[a] : 32'h0000_0000;
      end else begin
         tab_rd = (a < 9'(PAL_DEPTH)) ? pal_mem[a[7:0]] : 32'h0000_0000;
      end
   endfunction

   // register port decode
   wire        acc     = psel & penable;
   wire        hit_c1  = paddr == OFF_CTRL1;
   wire        hit_c2  = paddr == OFF_CTRL2;
   wire        hit_al  = paddr == OFF_ALPHA;
   wire        hit_td  = paddr == OFF_TDATA;
   wire        hit_lo  = paddr == OFF_KEYLO;
   wire        hit_hi  = paddr == OFF_KEYHI;
   wire        mapped  = hit_c1 | hit_c2 | hit_al | hit_td | hit_lo | hit_hi;
   wire        busy    = pl_q != PL_IDLE;
   // a table read must wait until the pre-load buffer is filled
   wire        stall   = acc & ~pwrite & hit_td & busy;
   wire        done    = acc & ~stall;
   wire        wr      = done & pwrite & mapped;
   wire        rd_en   = ctrl2_q[C2_RD];
   wire        ts      = ctrl2_q[C2_TS];
   wire [8:0]  taddr   = ctrl2_q[8:0];
   wire [8:0]  a1      = taddr + 9'h001;
   wire [8:0]  a2      = taddr + 9'h002;
   wire        td_rd   = done & ~pwrite & hit_td & rd_en;
   wire        td_wr   = wr & hit_td;
   wire        td_step = td_rd | td_wr;
   wire        c2_wr   = wr & hit_c2;
   wire        pl_go   = c2_wr & pwdata[C2_RD] &
                         (~rd_en | (pwdata[C2_TS] != ts) | (pwdata[8:0] != taddr));
   wire [31:0] td_view = rd_en ? buf0_q : 32'h0000_0000;

   assign pready  = ~stall;
   assign pslverr = acc & ~mapped;
   assign prdata  = ~(acc & ~pwrite) ? 32'h0000_0000 :
                    hit_c1 ? ctrl1_q :
                    hit_c2 ? ctrl2_q :
                    hit_al ? alpha_q :
                    hit_td ? td_view :
                    hit_lo ? keylo_q :
                    hit_hi ? keyhi_q : 32'h0000_0000;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl1_q <= CTRL1_RST;
         alpha_q <= ALPHA_RST;
         keylo_q <= KEY_RST;
         keyhi_q <= KEY_RST;
      end else if (wr) begin
         if (hit_c1) ctrl1_q <= pwdata;
         if (hit_al) alpha_q <= pwdata;
         if (hit_lo) keylo_q <= pwdata;
         if (hit_hi) keyhi_q <= pwdata;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl2_q <= CTRL2_RST;
      end else if (c2_wr) begin
         ctrl2_q <= pwdata;
      end else if (td_step) begin
         ctrl2_q[8:0] <= a1;
      end
   end

   // table writes land at the current address; out-of-range writes are dropped
   always_ff @(posedge clock) begin
      if (td_wr && ts && taddr < 9'(REV_DEPTH)) begin
         rev_mem[taddr] <= pwdata;
      end
      if (td_wr && !ts && taddr < 9'(PAL_DEPTH)) begin
         pal_mem[taddr[7:0]] <= pwdata;
      end
   end

   // pre-load: entry at the address, then the one after it
   always_comb begin
      pl_d = pl_q;
      case (pl_q)
         PL_IDLE:   pl_d = pl_go ? PL_FIRST : PL_IDLE;
         PL_FIRST:  pl_d = PL_SECOND;
         PL_SECOND: pl_d = pl_go ? PL_FIRST : PL_IDLE;
         default:   pl_d = PL_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pl_q   <= PL_IDLE;
         buf0_q <= 32'h0000_0000;
         buf1_q <= 32'h0000_0000;
      end else begin
         pl_q <= pl_d;
         if (pl_q == PL_FIRST) begin
            buf0_q <= tab_rd(ts, taddr);
         end else if (pl_q == PL_SECOND) begin
            buf1_q <= tab_rd(ts, a1);
         end else if (td_rd) begin
            buf0_q <= buf1_q;
            buf1_q <= tab_rd(ts, a2);
         end
      end
   end

   // conversion path
   wire [2:0]  fmt      = ctrl1_q[C1_FMT_LO +: 3];
   wire        pi       = ctrl2_q[C2_PI];
   wire [3:0]  keyen    = alpha_q[AL_KEY_LO +: 4];
   wire [7:0]  edge_a   = alpha_q[7:0];
   wire        sel_en   = ctrl1_q[C1_SEL_EN];
   wire [31:0] exp_w    = expand(fmt, in_data);
   wire [31:0] pal_w    = pal_mem[in_data[7:0]];
   // the palette flag wins over the 16-bit expansion when both are set
   wire [31:0] conv_w   = pi ? pal_w : exp_w;
   wire        key_on   = |keyen;
   wire        cur_t    = key_on & key_hit(conv_w, keylo_q, keyhi_q, keyen);
   wire [7:0]  cur_a    = ~key_on ? conv_w[31:24] :
                          cur_t ? ALPHA_CLEAR : ALPHA_OPAQUE;
   wire [31:0] cur_w    = {cur_a, conv_w[23:0]};
   // edge mode holds one pixel back to see its successor
   wire        edge_md  = key_on & (edge_a != ALPHA_OPAQUE);
   wire        next_t   = in_go & cur_t;
   wire        do_edge  = ~hold_t_q & (prev_t_q | next_t);
   wire [31:0] held_w   = do_edge ? {edge_a, hold_q[23:0]} : hold_q;
   wire        emit_cur = in_go & ~edge_md;
   wire        emit_hld = edge_md & hold_v_q & (in_go | in_flush);
   wire        fb_take  = fb_go & ~in_go & ~in_flush;
   wire [31:0] fb_w     = fb_buses[32*fb_sel +: 32];
   wire [31:0] pre_w    = emit_cur ? cur_w : emit_hld ? held_w : fb_w;
   wire        out_go   = emit_cur | emit_hld | fb_take;
   wire [31:0] vbus_d   = bsel(pre_w, ctrl1_q[7:0], sel_en);

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         vbus_data_q  <= 32'h0000_0000;
         vbus_size_q  <= 2'h0;
         vbus_valid_q <= 1'b0;
      end else begin
         vbus_valid_q <= out_go;
         if (out_go) begin
            vbus_data_q <= vbus_d;
            vbus_size_q <= ctrl1_q[C1_SIZE_LO +: 2];
         end
      end
   end

   // a pixel still held when edge mode is switched off is lost; flush first
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hold_q   <= 32'h0000_0000;
         hold_t_q <= 1'b0;
         hold_v_q <= 1'b0;
         prev_t_q <= 1'b0;
      end else if (edge_md && in_go) begin
         hold_q   <= cur_w;
         hold_t_q <= cur_t;
         hold_v_q <= 1'b1;
         prev_t_q <= hold_v_q & hold_t_q;
      end else if (in_flush || !edge_md) begin
         hold_v_q <= 1'b0;
         prev_t_q <= 1'b0;
      end
   end

   // reverse table lookup port
   wire [2:0]  rl_r  = lim(rev_red, ctrl2_q[C2_RCNT_LO +: 3]);
   wire [2:0]  rl_g  = lim(rev_green, ctrl2_q[C2_GCNT_LO +: 3]);
   wire [2:0]  rl_b  = lim(rev_blue, ctrl2_q[C2_BCNT_LO +: 3]);
   // blue levels above five fall off the table and read as zero
   wire [8:0]  r_idx = {6'h00, rl_r} + 9'(REV_G_STRIDE * rl_g)
                       + 9'(REV_B_STRIDE * rl_b);
   wire [31:0] r_ent = tab_rd(1'b1, r_idx);

   // errors are stored as written: clamping to 2.4 range is up to software
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rev_pseudo_q <= 8'h00;
         rev_error_q  <= 18'h00000;
         rev_next_q   <= 6'h00;
      end else begin
         rev_pseudo_q <= r_ent[RV_PSEUDO +: 8];
         rev_error_q  <= {r_ent[RV_RERR +: 6], r_ent[RV_GERR +: 6],
                          r_ent[RV_BERR +: 6]};
         rev_next_q   <= {r_ent[RV_RNXT +: 2], r_ent[RV_GNXT +: 2],
                          r_ent[RV_BNXT +: 2]};
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_fb_result: assert property (fb_take |=> vbus_valid_q &&
      vbus_data_q == bsel($past(fb_w), $past(ctrl1_q[7:0]), $past(sel_en)))
      else $error("feedback result wrong or late");
   a_input_pass: assert property (emit_cur && fmt == FMT_PASS && !pi && !sel_en
      && !key_on |=> vbus_data_q == $past(in_data))
      else $error("pass-through input altered");
   a_size_tag: assert property (out_go |=> vbus_size_q == $past(ctrl1_q[11:10]))
      else $error("size tag not attached");
   // key checks follow the pixel into the vbus register, not only the alpha mux
   a_key_binary: assert property (emit_cur && !sel_en && keyen[0] &&
      conv_w[7:0] > keyhi_q[7:0] |=> vbus_data_q[31:24] == ALPHA_OPAQUE)
      else $error("key alpha not opaque outside range");
   a_key_clear: assert property (emit_cur && !sel_en && key_on && cur_t
      |=> vbus_data_q[31:24] == ALPHA_CLEAR)
      else $error("key alpha not zero inside range");
   a_key_off: assert property (emit_cur && !sel_en && !key_on
      |=> vbus_data_q[31:24] == $past(conv_w[31:24]))
      else $error("alpha changed with keys off");
   a_expand_565: assert property (!pi && fmt == FMT_565 |-> conv_w[23:16] ==
      {in_data[15:11], in_data[15:13]} && conv_w[15:8] == {in_data[10:5], in_data[10:9]})
      else $error("565 expansion wrong");
   a_rd_gate: assert property (acc && !pwrite && hit_td && !rd_en |-> prdata == 0)
      else $error("table read while read flag clear");
   a_preload_len: assert property (pl_go |=> busy [*2] ##1 (!busy || $past(pl_go)))
      else $error("pre-load not two cycles");
   a_auto_inc: assert property (td_step && !c2_wr |=> taddr == $past(a1))
      else $error("table address not incremented");
   a_swap_byte: assert property (emit_cur && sel_en && ctrl1_q[7:0] == 8'h1B
      |=> vbus_data_q == {$past(cur_w[7:0]), $past(cur_w[15:8]),
                          $past(cur_w[23:16]), $past(cur_w[31:24])})
      else $error("byte reversal wrong");
   a_palette_in: assert property (emit_cur && pi && !key_on && !sel_en
      |=> vbus_data_q == $past(pal_w))
      else $error("palette lookup not stored");
   // edge mode: the first pixel is only held, a flush pushes the held one out
   a_edge_first: assert property (edge_md && in_go && !hold_v_q |=> !vbus_valid_q)
      else $error("edge mode emitted without a held pixel");
   a_edge_flush: assert property (edge_md && in_flush && hold_v_q |=> vbus_valid_q)
      else $error("flush did not push out held pixel");
   a_rd_noinc: assert property (acc && !pwrite && hit_td && !rd_en
      |=> taddr == $past(taddr))
      else $error("gated table read moved the address");
   a_rev_clamp: assert property (ctrl2_q[C2_RCNT_LO +: 3] != 3'h0
      |-> rl_r < ctrl2_q[C2_RCNT_LO +: 3])
      else $error("red index beyond level count");

   c_palette_in: cover property (in_go && pi && !edge_md ##1 vbus_valid_q);
   c_edge_pixel: cover property (emit_hld && do_edge);
   c_table_read: cover property (pl_go ##[1:8] td_rd);
   c_feedback: cover property (fb_take && sel_en);
   c_key_clear: cover property (emit_cur && key_on && cur_t);
endmodule
`default_nettype wire

// *** vicc_pkg.sv ***
// constants, field positions and types of the video input colour converter
// assumes a 32-bit apb register port and one 200 MHz clock
package vicc_pkg;
   localparam logic [7:0]  OFF_CTRL1 = 8'h00;
   localparam logic [7:0]  OFF_CTRL2 = 8'h04;
   localparam logic [7:0]  OFF_ALPHA = 8'h08;
   localparam logic [7:0]  OFF_TDATA = 8'h0C;
   localparam logic [7:0]  OFF_KEYLO = 8'h10;
   localparam logic [7:0]  OFF_KEYHI = 8'h14;
   localparam logic [31:0] CTRL1_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL2_RST = 32'h0000_0000;
   localparam logic [31:0] ALPHA_RST = 32'h0000_00FF;
   localparam logic [31:0] KEY_RST   = 32'h0000_0000;
   localparam int C1_FMT_LO  = 29;
   localparam int C1_SIZE_LO = 10;
   localparam int C1_SEL_EN  = 9;
   localparam int C2_PI      = 31;
   localparam int C2_RCNT_LO = 18;
   localparam int C2_GCNT_LO = 15;
   localparam int C2_BCNT_LO = 12;
   localparam int C2_RD      = 10;
   localparam int C2_TS      = 9;
   localparam int AL_KEY_LO  = 8;
   localparam int RV_PSEUDO  = 24;
   localparam int RV_RERR    = 18;
   localparam int RV_RNXT    = 16;
   localparam int RV_GERR    = 10;
   localparam int RV_GNXT    = 8;
   localparam int RV_BERR    = 2;
   localparam int RV_BNXT    = 0;
   localparam int PAL_DEPTH  = 256;
   localparam int REV_DEPTH  = 384;
   localparam logic [8:0]  REV_G_STRIDE = 9'h008;
   localparam logic [8:0]  REV_B_STRIDE = 9'h040;
   localparam logic [7:0]  ALPHA_OPAQUE = 8'hFF;
   localparam logic [7:0]  ALPHA_CLEAR  = 8'h00;
   typedef enum logic [2:0] {
      FMT_PASS = 3'b000,
      FMT_1555 = 3'b001,
      FMT_565  = 3'b010,
      FMT_4444 = 3'b011,
      FMT_0555 = 3'b101,
      FMT_R565 = 3'b110
   } vicc_fmt_type;
   typedef enum logic [1:0] {
      PL_IDLE   = 2'b00,
      PL_FIRST  = 2'b01,
      PL_SECOND = 2'b10
   } vicc_pl_type;
endpackage

// *** vicc_image_bus_model.sv ***
// image bus model: presents one word, or a flush request, to the converter
// assumes the bench raises send or flush for one cycle, right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module vicc_image_bus_model (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        send,
   input  wire logic        flush,
   input  wire logic [31:0] word,
   output logic             in_go,
   output logic             in_flush,
   output logic      [31:0] in_data
);
   // a released bus inverts its value every cycle, so a sample one cycle late never matches
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         in_go    <= 1'b0;
         in_flush <= 1'b0;
         in_data  <= 32'h0000_0000;
      end else begin
         in_go    <= send;
         in_flush <= flush;
         in_data  <= send ? word : ~in_data;
      end
   end
endmodule
`default_nettype wire

// *** tb.sv ***
// self-checking bench of the video input colour converter
// assumes the converter answers apb within a few waits and converts one pixel per go
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
   $display("FAIL at %0t: got %h expected %h", $time, got, exp); end end
module tb;
   import vicc_pkg::*;
   logic          clock, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0]    paddr;
   logic [31:0]   pwdata, prdata, in_data, vbus_data_q, img_word, r;
   logic          in_go, in_flush, fb_go, vbus_valid_q, img_send, img_flush, e;
   logic [2:0]    fb_sel, rev_red, rev_green, rev_blue;
   logic [255:0]  fb_buses;
   logic [1:0]    vbus_size_q;
   logic [7:0]    rev_pseudo_q;
   logic [17:0]   rev_error_q;
   logic [5:0]    rev_next_q;
   int            failures, samples_checked, cycles;

   vicc_core vicc_core_inst (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .in_go(in_go), .in_data(in_data), .in_flush(in_flush),
      .fb_go(fb_go), .fb_sel(fb_sel), .fb_buses(fb_buses), .vbus_data_q(vbus_data_q),
      .vbus_size_q(vbus_size_q), .vbus_valid_q(vbus_valid_q), .rev_red(rev_red),
      .rev_green(rev_green), .rev_blue(rev_blue), .rev_pseudo_q(rev_pseudo_q),
      .rev_error_q(rev_error_q), .rev_next_q(rev_next_q));
   vicc_image_bus_model vicc_image_bus_model_inst (.clock(clock), .rst_n(rst_n),
      .send(img_send), .flush(img_flush), .word(img_word), .in_go(in_go),
      .in_flush(in_flush), .in_data(in_data));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // the whole run is a few hundred cycles; the ceiling leaves ample margin
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         complete_run();
      end
   end

   // request is held unchanged until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic er);
      int n;
      logic rdy;
      n = 0;
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      // read data and ready are taken at the edge that ends the access phase
      do begin
         @(posedge clock);
         n++;
         rd  = prdata;
         er  = pslverr;
         rdy = pready;
      end while (rdy !== 1'b1);
      // at most two waits, and only while a pre-load is running
      `CHK(n < 4, 1'b1)
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0000_0000, rd, er);
      `CHK(rd, x)
   endtask

   task automatic pix(input logic [31:0] d, input logic fl);
      @(posedge clock);
      img_send  <= !fl;
      img_flush <= fl;
      img_word  <= d;
      @(posedge clock);
      img_send  <= 1'b0;
      img_flush <= 1'b0;
   endtask

   task automatic expect_vbus(input logic [31:0] d, input logic [1:0] sz);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (vbus_valid_q !== 1'b1 && n < 10);
      `CHK(vbus_valid_q, 1'b1)
      `CHK(vbus_data_q, d)
      `CHK(vbus_size_q, sz)
   endtask

   function automatic logic [7:0] r5(input logic [4:0] x);
      return {x, x[4:2]};
   endfunction

   function automatic logic [31:0] expand(input logic [2:0] f, input logic [31:0] d);
      logic [15:0] h;
      h = d[15:0];
      case (f)
         3'b001:  return {{8{h[15]}}, r5(h[14:10]), r5(h[9:5]), r5(h[4:0])};
         3'b010:  return {8'hFF, r5(h[15:11]), h[10:5], h[10:9], r5(h[4:0])};
         3'b011:  return {{2{h[15:12]}}, {2{h[11:8]}}, {2{h[7:4]}}, {2{h[3:0]}}};
         3'b101:  return {8'hFF, r5(h[14:10]), r5(h[9:5]), r5(h[4:0])};
         3'b110:  return {8'hFF, r5(h[4:0]), h[10:5], h[10:9], r5(h[15:11])};
         default: return d;
      endcase
   endfunction

   initial begin
      {psel, penable, pwrite, img_send, img_flush, fb_go} = 6'h00;
      {paddr, pwdata, img_word, fb_sel, rev_red, rev_green, rev_blue} = '0;
      for (int i = 0; i < 8; i++) fb_buses[32*i +: 32] = 32'h4030_2010 + {4{8'(i)}};
      failures = 0;
      samples_checked = 0;
      cycles = 0;
      rst_n = 1'b0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      rd_chk(OFF_CTRL1, CTRL1_RST);
      rd_chk(OFF_CTRL2, CTRL2_RST);
      rd_chk(OFF_ALPHA, ALPHA_RST);
      rd_chk(OFF_KEYLO, KEY_RST);
      rd_chk(OFF_KEYHI, KEY_RST);
      apb(1'b0, 8'h20, 32'h0000_0000, r, e);
      `CHK(e, 1'b1)
      wr(OFF_KEYLO, 32'h0020_2020);
      rd_chk(OFF_KEYLO, 32'h0020_2020);
      wr(OFF_KEYHI, 32'hFF40_4040);
      // every format code, the size tag riding along as the format's low two bits, so each tag code twice
      for (int f = 0; f < 8; f++) begin
         wr(OFF_CTRL1, {f[2:0], 17'h0, f[1:0], 10'h000});
         pix(32'h0000_A5C3, 1'b0);
         expect_vbus(expand(f[2:0], 32'h0000_A5C3), f[1:0]);
      end
      wr(OFF_CTRL1, 32'h0000_021B);
      pix(32'h1122_3344, 1'b0);
      expect_vbus(32'h4433_2211, 2'b00);
      wr(OFF_CTRL1, 32'h0000_001B);
      pix(32'h1122_3344, 1'b0);
      expect_vbus(32'h1122_3344, 2'b00);
      wr(OFF_CTRL1, 32'h0000_0E1B);
      @(posedge clock);
      fb_go  <= 1'b1;
      fb_sel <= 3'd5;
      @(posedge clock);
      fb_go  <= 1'b0;
      #1;
      `CHK(vbus_valid_q, 1'b1)
      `CHK(vbus_data_q, 32'h1525_3545)
      `CHK(vbus_size_q, 2'b11)
      wr(OFF_CTRL1, 32'h0000_0000);
      wr(OFF_ALPHA, 32'h0000_0FFF);
      pix(32'h1230_3030, 1'b0);
      expect_vbus(32'h0030_3030, 2'b00);
      pix(32'h1230_3050, 1'b0);
      expect_vbus(32'hFF30_3050, 2'b00);
      wr(OFF_ALPHA, 32'h0000_00FF);
      pix(32'h1230_3050, 1'b0);
      expect_vbus(32'h1230_3050, 2'b00);
      // edge mode holds one pixel, so each result leaves with the following go or flush
      wr(OFF_ALPHA, 32'h0000_0F80);
      pix(32'h1250_5050, 1'b0);
      pix(32'h1230_3030, 1'b0);
      expect_vbus(32'h8050_5050, 2'b00);
      pix(32'h1260_6060, 1'b0);
      expect_vbus(32'h0030_3030, 2'b00);
      pix(32'h0000_0000, 1'b1);
      expect_vbus(32'h8060_6060, 2'b00);
      wr(OFF_ALPHA, 32'h0000_00FF);
      wr(OFF_CTRL2, 32'h0000_0005);
      wr(OFF_TDATA, 32'h80FF_0000);
      wr(OFF_TDATA, 32'h4011_2233);
      rd_chk(OFF_TDATA, 32'h0000_0000);
      wr(OFF_CTRL2, 32'h0000_0405);
      rd_chk(OFF_TDATA, 32'h80FF_0000);
      rd_chk(OFF_TDATA, 32'h4011_2233);
      wr(OFF_CTRL2, 32'h8000_0000);
      pix(32'h0000_0006, 1'b0);
      expect_vbus(32'h4011_2233, 2'b00);
      // reverse entry index 3 + 8*2 + 64*5, red and green errors at the clamp limits
      wr(OFF_CTRL2, 32'h0000_0353);
      wr(OFF_TDATA, 32'hA77E_8117);
      @(posedge clock);
      rev_red   <= 3'd3;
      rev_green <= 3'd2;
      rev_blue  <= 3'd5;
      repeat (2) @(posedge clock);
      #1;
      `CHK(rev_pseudo_q, 8'hA7)
      `CHK(rev_error_q, {6'h1F, 6'h20, 6'h05})
      `CHK(rev_next_q, 6'b10_01_11)
      wr(OFF_CTRL2, 32'h0008_0351);
      wr(OFF_TDATA, 32'h5A00_0000);
      @(posedge clock);
      #1;
      `CHK(rev_pseudo_q, 8'h5A)
      complete_run();
   end
endmodule
`default_nettype wire
